// >>> hdl/dir_overcurrent_block.sv
// Purpose: Four directional overcurrent stages with an APB register file.
// Assumes: Front end delivers one sample set per meas_valid pulse.
// Notes:   Delay characteristics and logging are outside this block.
//
// Functional notes
// - Magnitude select: fundamental, true RMS, peak-to-peak.
// - Direction angle: current minus voltage reference.
// - Positive-sequence voltage angle is normal reference.
// - Line-to-line mode uses healthy-phase voltage angle.
// - Short-circuit uses impedance-derived reference angle.
// - Below 1 V hold memory 0.5 s, then 0 deg.
// - Angle memory keeps angle 100 ms before fault.
// - Common threshold; any phase above picks up.
// - Release below 97 percent of threshold.
// - Threshold in 0.01 In steps, default 1.20.
// - Direction mode select, default directional.
// - Non-directional trips on magnitude alone.
// - Directional needs angle inside sector, default 88.
// - Sector centre settable, default 0 deg.
// - Two degree hysteresis at sector boundary.
// - Operating state select, gated by global enable.
// - Forced status when forcing globally enabled.
// - General settings ignore setting group changes.
// - Pick-up and direction follow active group.
// - Four independent stage copies.
// - Block at pick-up gives blocked, resets start.
`timescale 1ns/1ps
module dir_overcurrent_block
    import doc_stage_pkg::*;
#(
    parameter int STAGES      = NUM_STAGES,
    parameter int HOLD_CNT    = HOLD_CYCLES,
    parameter int PREFAULT_CNT = PREFAULT_CYCLES
) (
    // Clock and reset.
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // APB slave.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    // Measurement front end.
    input  wire logic               meas_valid,
    input  wire logic [15:0]        fund_l1,
    input  wire logic [15:0]        fund_l2,
    input  wire logic [15:0]        fund_l3,
    input  wire logic [15:0]        true_rms_magnitude_l1,
    input  wire logic [15:0]        true_rms_magnitude_l2,
    input  wire logic [15:0]        true_rms_magnitude_l3,
    input  wire logic [15:0]        pp_l1,
    input  wire logic [15:0]        pp_l2,
    input  wire logic [15:0]        pp_l3,
    input  wire logic [15:0]        i1_angle,
    input  wire logic [15:0]        u1_angle,
    input  wire logic               u1_available,
    input  wire logic               line_to_line_only_mode,
    input  wire logic [15:0]        healthy_ll_angle,
    input  wire logic               short_circuit,
    input  wire logic [15:0]        impedance_angle,
    input  wire logic [15:0]        u_secondary_mv,
    // Trip logic side.
    input  wire logic [STAGES-1:0]  block_in,
    output logic [STAGES-1:0]       stage_start,
    output logic [STAGES-1:0]       stage_trip,
    output logic [STAGES-1:0]       stage_blocked
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Wraps a signed angle difference into -180..180 degrees.
    function automatic logic signed [15:0] wrap(input logic signed [16:0] a);
        logic signed [16:0] r;
        r = a;
        if (r > $signed({1'b0, ANGLE_HALF})) begin
            r = r - $signed({1'b0, ANGLE_FULL});
        end else if (r < -$signed({1'b0, ANGLE_HALF})) begin
            r = r + $signed({1'b0, ANGLE_FULL});
        end
        return r[15:0];
    endfunction : wrap

    // Absolute value of a wrapped angle.
    function automatic logic [15:0] absang(input logic signed [15:0] a);
        return a[15] ? 16'(-a) : 16'(a);
    endfunction : absang

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [31:0] general [STAGES];
    logic [1:0]  group_sel;
    logic [15:0] grp_pickup [NUM_GROUPS][STAGES];
    logic [15:0] grp_halfw  [NUM_GROUPS][STAGES];
    logic [15:0] grp_center [NUM_GROUPS][STAGES];
    logic        grp_nondir [NUM_GROUPS][STAGES];
    logic [15:0] ref_angle;
    logic signed [15:0] dir_angle;

    wire         wr_en  = psel && penable && pwrite;
    wire  [1:0]  stg    = paddr[3:2];
    wire         in_grp = paddr >= OFS_GRP_BASE;
    wire  [7:0]  grel   = paddr - OFS_GRP_BASE;
    wire  [1:0]  gidx   = grel[7:6];
    wire  [1:0]  gstg   = grel[5:4];
    wire  [1:0]  gfld   = grel[3:2];

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // General settings are per stage and independent of groups.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int s = 0; s < STAGES; s++) begin
                general[s] <= '0;
            end
        end else if (wr_en && !in_grp && paddr[7:4] == OFS_GENERAL[7:4]) begin
            general[stg] <= pwdata;
        end
    end

    // Active group pointer.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            group_sel <= '0;
        end else if (wr_en && paddr == OFS_STATUS + 8'h0c) begin
            group_sel <= pwdata[1:0];
        end
    end

    // Group settings, each group holding four stage slots.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                for (int s = 0; s < STAGES; s++) begin
                    grp_pickup[g][s] <= PICKUP_RESET;
                    grp_halfw[g][s]  <= HALFW_RESET;
                    grp_center[g][s] <= CENTER_RESET;
                    grp_nondir[g][s] <= 1'b0;
                end
            end
        end else if (wr_en && in_grp) begin
            unique case (gfld)
                2'd0: grp_pickup[gidx][gstg] <= pwdata[15:0];
                2'd1: grp_halfw[gidx][gstg]  <= pwdata[15:0];
                2'd2: grp_center[gidx][gstg] <= pwdata[15:0];
                2'd3: grp_nondir[gidx][gstg] <= pwdata[0];
            endcase
        end
    end

    // Read data, registered at the setup phase.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (in_grp) begin
                unique case (gfld)
                    2'd0: prdata <= {16'h0000, grp_pickup[gidx][gstg]};
                    2'd1: prdata <= {16'h0000, grp_halfw[gidx][gstg]};
                    2'd2: prdata <= {16'h0000, grp_center[gidx][gstg]};
                    2'd3: prdata <= {31'h0, grp_nondir[gidx][gstg]};
                endcase
            end else if (paddr[7:4] == OFS_GENERAL[7:4]) begin
                prdata <= general[stg];
            end else if (paddr == OFS_STATUS) begin
                prdata <= {20'h0, stage_blocked, stage_trip, stage_start};
            end else if (paddr == OFS_ANGLE) begin
                prdata <= {ref_angle, dir_angle};
            end else if (paddr == OFS_STATUS + 8'h0c) begin
                prdata <= {30'h0, group_sel};
            end else begin
                prdata <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Reference angle and voltage memory
    // ---------------------------------------------------------------
    logic [15:0] live_ref;
    logic [15:0] delay_line;
    logic [15:0] angle_mem;
    logic [31:0] pre_cnt;
    logic [31:0] hold_cnt;
    logic        any_pickup;
    logic        vloss;

    // Pick the live reference source.
    always_comb begin
        if (short_circuit) begin
            live_ref = impedance_angle;
        end else if (line_to_line_only_mode) begin
            live_ref = healthy_ll_angle;
        end else if (u1_available) begin
            live_ref = u1_angle;
        end else begin
            live_ref = u1_angle;
        end
    end

    assign vloss = u_secondary_mv < VLOSS_MV;

    // Delayed angle tap refreshed every pre-fault interval.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pre_cnt    <= '0;
            delay_line <= '0;
            angle_mem  <= '0;
        end else if (!any_pickup && !vloss) begin
            if (pre_cnt >= 32'(PREFAULT_CNT - 1)) begin
                pre_cnt    <= '0;
                angle_mem  <= delay_line;
                delay_line <= live_ref;
            end else begin
                pre_cnt <= pre_cnt + 32'd1;
            end
        end
    end

    // Hold timer during voltage loss.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hold_cnt <= '0;
        end else if (!vloss) begin
            hold_cnt <= '0;
        end else if (hold_cnt < 32'(HOLD_CNT)) begin
            hold_cnt <= hold_cnt + 32'd1;
        end
    end

    // Effective reference angle.
    always_comb begin
        if (!vloss) begin
            ref_angle = live_ref;
        end else if (hold_cnt < 32'(HOLD_CNT)) begin
            ref_angle = angle_mem;
        end else begin
            ref_angle = '0;
        end
    end

    assign dir_angle = wrap(17'($signed(i1_angle)) -
                            17'($signed(ref_angle)));

    // ---------------------------------------------------------------
    // Stage copies
    // ---------------------------------------------------------------
    logic [STAGES-1:0] picked;
    logic [STAGES-1:0] in_sector;
    assign any_pickup = |picked;

    for (genvar s = 0; s < STAGES; s++) begin : g_stage
        logic [15:0] m1, m2, m3, thr, hw, ctr;
        logic [31:0] rel_thr;
        logic signed [15:0] off;
        logic        over, under, nondir, dir_ok, lnen, fen;
        stage_operating_state_e opst;
        force_status_e          fst;
        magnitude_sel_e         msel;

        assign opst  = stage_operating_state_e'(general[s][GEN_STATE_LSB +: 3]);
        assign fst   = force_status_e'(general[s][GEN_FORCE_LSB +: 2]);
        assign msel  = magnitude_sel_e'(general[s][GEN_MAG_LSB +: 2]);
        assign lnen  = general[s][GEN_LNEN_BIT];
        assign fen   = general[s][GEN_FEN_BIT];
        assign thr    = grp_pickup[group_sel][s];
        assign hw     = grp_halfw[group_sel][s];
        assign ctr    = grp_center[group_sel][s];
        assign nondir = grp_nondir[group_sel][s];

        // Magnitude selection per phase.
        always_comb begin
            unique case (msel)
                MAG_TRUE_RMS: begin
                    m1 = true_rms_magnitude_l1; m2 = true_rms_magnitude_l2; m3 = true_rms_magnitude_l3;
                end
                MAG_PEAK_TO_PEAK: begin
                    m1 = pp_l1; m2 = pp_l2; m3 = pp_l3;
                end
                default: begin
                    m1 = fund_l1; m2 = fund_l2; m3 = fund_l3;
                end
            endcase
        end

        // Pick-up above threshold, release below 97 percent.
        assign rel_thr = (32'(thr) * 32'(RESET_RATIO_PCT));
        assign over  = m1 > thr || m2 > thr || m3 > thr;
        assign under = 32'(m1) * 32'(PCT_FULL) < rel_thr &&
                       32'(m2) * 32'(PCT_FULL) < rel_thr &&
                       32'(m3) * 32'(PCT_FULL) < rel_thr;

        // Sector check with boundary hysteresis.
        assign off = wrap(17'(dir_angle) - 17'($signed(ctr)));
        assign dir_ok = in_sector[s]
            ? absang(off) <= hw + HYST_ANGLE
            : absang(off) <= hw;

        // Stage state updated on each measurement set.
        always_ff @(posedge sys_clk) begin
            if (!rstn) begin
                picked[s]        <= 1'b0;
                in_sector[s]     <= 1'b0;
                stage_start[s]   <= 1'b0;
                stage_trip[s]    <= 1'b0;
                stage_blocked[s] <= 1'b0;
            end else if (meas_valid) begin
                in_sector[s] <= dir_ok;
                picked[s] <= picked[s] ? !under : over;
                if (fen) begin
                    stage_start[s]   <= fst == FS_START;
                    stage_trip[s]    <= fst == FS_TRIP;
                    stage_blocked[s] <= fst == FS_BLOCKED;
                end else if (lnen && opst == ST_OFF) begin
                    stage_start[s]   <= 1'b0;
                    stage_trip[s]    <= 1'b0;
                    stage_blocked[s] <= 1'b0;
                end else if (block_in[s] || (lnen &&
                         (opst == ST_BLOCKED || opst == ST_TEST_BLOCKED))) begin
                    stage_start[s]   <= 1'b0;
                    stage_trip[s]    <= 1'b0;
                    stage_blocked[s] <= picked[s] ? !under : over;
                end else begin
                    stage_blocked[s] <= 1'b0;
                    stage_start[s]   <= picked[s] ? !under : over;
                    stage_trip[s]    <= (picked[s] ? !under : over) &&
                                        (nondir || dir_ok);
                end
            end
        end
    end

endmodule : dir_overcurrent_block

// >>> shared/doc_stage_pkg.sv
// Purpose: Constants and types shared by the directional overcurrent stage.
// Assumes: Currents in units of 0.01 x nominal, angles in units of 0.1 deg.
// Notes:   Register map is byte addressed on a 32-bit APB bus.
package doc_stage_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_GENERAL  = 8'h00;
    localparam logic [7:0] OFS_GROUPSEL = 8'h04;
    localparam logic [7:0] OFS_PICKUP   = 8'h08;
    localparam logic [7:0] OFS_SECTOR   = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_ANGLE    = 8'h14;
    localparam int         GRP_STRIDE   = 16;
    localparam int         NUM_GROUPS   = 4;
    localparam logic [7:0] OFS_GRP_BASE = 8'h20;

    // ---------------------------------------------------------------
    // Field layouts of the general register
    // ---------------------------------------------------------------
    localparam int GEN_STATE_LSB = 0;
    localparam int GEN_FORCE_LSB = 4;
    localparam int GEN_MAG_LSB   = 8;
    localparam int GEN_LNEN_BIT  = 12;
    localparam int GEN_FEN_BIT   = 13;

    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ON, ST_BLOCKED, ST_TEST, ST_TEST_BLOCKED, ST_OFF
    } stage_operating_state_e;

    typedef enum logic [1:0] {
        FS_NORMAL, FS_START, FS_TRIP, FS_BLOCKED
    } force_status_e;

    typedef enum logic [1:0] {
        MAG_FUNDAMENTAL, MAG_TRUE_RMS, MAG_PEAK_TO_PEAK
    } magnitude_sel_e;

    // ---------------------------------------------------------------
    // Reset values and fixed figures
    // ---------------------------------------------------------------
    localparam logic [15:0] PICKUP_RESET  = 16'd120;
    localparam logic [15:0] HALFW_RESET   = 16'd880;
    localparam logic [15:0] CENTER_RESET  = 16'h0000;
    localparam logic [15:0] HYST_ANGLE    = 16'd20;
    localparam int          RESET_RATIO_PCT = 97;
    localparam int          PCT_FULL      = 100;
    localparam logic [15:0] VLOSS_MV      = 16'd1000;
    localparam logic [15:0] ANGLE_FULL    = 16'd3600;
    localparam logic [15:0] ANGLE_HALF    = 16'd1800;
    localparam int          CLK_MHZ       = 200;
    localparam int          HOLD_MS       = 500;
    localparam int          PREFAULT_MS   = 100;
    localparam int          HOLD_CYCLES   = HOLD_MS * 1000 * CLK_MHZ;
    localparam int          PREFAULT_CYCLES = PREFAULT_MS * 1000 * CLK_MHZ;
    localparam int          NUM_STAGES    = 4;

endpackage : doc_stage_pkg

// >>> dv/frontend_model.sv
// Purpose: Measurement front end model for the overcurrent stage bench.
// Assumes: One sample set is launched per send request.
// Notes:   Values stand unchanged between two valid pulses.
`timescale 1ns/1ps
module frontend_model (
    // Clock and request from the bench.
    input  wire logic        sys_clk,
    input  wire logic        send,
    input  wire logic [15:0] f_one,
    input  wire logic [15:0] f_rest,
    input  wire logic [15:0] p_all,
    // Sample set towards the stage.
    output logic             meas_valid = 1'b0,
    output logic [15:0]      fund_l1 = 16'h0000,
    output logic [15:0]      fund_l23 = 16'h0000,
    output logic [15:0]      pp_all = 16'h0000
);
    // Publish one sample set together with a single-cycle valid pulse.
    always_ff @(posedge sys_clk) begin
        meas_valid <= send;
        if (send) begin
            fund_l1  <= f_one;
            fund_l23 <= f_rest;
            pp_all   <= p_all;
        end
    end
endmodule : frontend_model

// >>> dv/dir_overcurrent_block_assertions.sv
// Purpose: Port-level checks for the directional overcurrent block.
// Assumes: Sees only the ports of the top module.
// Notes:   Default figures hold until the first register write.
`timescale 1ns/1ps
module dir_overcurrent_block_assertions #(
    parameter int STAGES = 4
) (
    // Clock, reset and register bus.
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Measurements and stage outputs.
    input wire logic              meas_valid,
    input wire logic [15:0]       fund_l1,
    input wire logic [15:0]       fund_l2,
    input wire logic [15:0]       fund_l3,
    input wire logic [STAGES-1:0] block_in,
    input wire logic [STAGES-1:0] stage_start,
    input wire logic [STAGES-1:0] stage_trip,
    input wire logic [STAGES-1:0] stage_blocked
);
    logic wrote;
    logic forcing;
    wire  fresh = !wrote && block_in == '0;
    wire  hot   = fund_l1 > 16'h0078 || fund_l2 > 16'h0078
                  || fund_l3 > 16'h0078;
    wire  calm  = fund_l1 <= 16'h0074 && fund_l2 <= 16'h0074
                  && fund_l3 <= 16'h0074;

    // Track writes since reset, as forcing may drive outputs on its own.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wrote   <= 1'b0;
            forcing <= 1'b0;
        end else if (psel && penable && pwrite) begin
            wrote   <= 1'b1;
            forcing <= forcing | (paddr < 8'h10 && pwdata[13]);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_no_slave_error: assert property (psel |-> !pslverr)
        else $error("slave error raised");
    a_hold_between: assert property (
        !meas_valid && !$past(meas_valid) |=>
        $stable({stage_start, stage_trip, stage_blocked}))
        else $error("outputs moved without a sample set");
    a_reset_clear: assert property (disable iff (1'b0)
        !rstn |=> {stage_start, stage_trip, stage_blocked} == '0)
        else $error("outputs not cleared by reset");
    a_default_pickup: assert property (
        meas_valid && fresh && hot |-> ##2 stage_start == '1)
        else $error("no pick-up above default threshold");
    a_default_release: assert property (
        meas_valid && fresh && calm |-> ##2 stage_start == '0)
        else $error("no release below reset ratio");
    a_trip_needs_start: assert property (
        !forcing |-> (stage_trip & ~stage_start) == '0)
        else $error("trip without pick-up");
    a_block_no_trip: assert property (
        !forcing |-> (stage_blocked & stage_trip) == '0)
        else $error("blocked stage tripped");
endmodule : dir_overcurrent_block_assertions

bind dir_overcurrent_block dir_overcurrent_block_assertions #(
    .STAGES(STAGES)
) u_chk (
    .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .meas_valid, .fund_l1, .fund_l2, .fund_l3, .block_in,
    .stage_start, .stage_trip, .stage_blocked
);

// >>> dv/dir_overcurrent_block_tb.sv
// Purpose: Self-checking bench for the directional overcurrent block.
// Assumes: Shortened hold counts and a zero-wait register bus.
// Notes:   Each scenario task drives and judges its own traffic.
`timescale 1ns/1ps
module dir_overcurrent_block_tb;
    import doc_stage_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0, send = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, meas_valid;
    logic [15:0] f_one = 16'h0, f_rest = 16'h0, p_all = 16'h0;
    logic [15:0] fund1, fund23, pp_v, i_ang = 16'h0, u_ang = 16'h0;
    logic [15:0] u_mv = 16'h1388;
    logic        ll_only = 1'b0, sc = 1'b0;
    logic [3:0]  block_in = 4'h0, stage_start, stage_trip, stage_blocked;
    int          mismatches = 0, checks_done = 0, cycles = 0;

    // Clock at 200 MHz.
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    frontend_model fe (.sys_clk(sys_clk), .send(send), .f_one(f_one),
        .f_rest(f_rest), .p_all(p_all), .meas_valid(meas_valid),
        .fund_l1(fund1), .fund_l23(fund23), .pp_all(pp_v));

    dir_overcurrent_block #(.HOLD_CNT(50), .PREFAULT_CNT(10)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .meas_valid(meas_valid),
        .fund_l1(fund1), .fund_l2(fund23), .fund_l3(fund23),
        .true_rms_magnitude_l1(fund1), .true_rms_magnitude_l2(fund1), .true_rms_magnitude_l3(fund1),
        .pp_l1(pp_v), .pp_l2(pp_v), .pp_l3(pp_v), .i1_angle(i_ang),
        .u1_angle(u_ang), .u1_available(1'b1),
        .line_to_line_only_mode(ll_only), .healthy_ll_angle(16'h0000),
        .short_circuit(sc), .impedance_angle(16'h0000),
        .u_secondary_mv(u_mv), .block_in(block_in),
        .stage_start(stage_start), .stage_trip(stage_trip),
        .stage_blocked(stage_blocked));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : compare

    // One register bus transfer; ready is sampled at each rising edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        compare(q, exp);
    endtask : rd_chk

    function automatic logic [7:0] grp(input int g, input int s, input int f);
        return 8'h20 + 8'(64 * g + 16 * s + 4 * f);
    endfunction : grp

    // Send a sample set and stop once its outputs have settled.
    task automatic sample(input logic [15:0] a, input logic [15:0] b,
                          input logic [15:0] p);
        @(posedge sys_clk);
        f_one  <= a;
        f_rest <= b;
        p_all  <= p;
        send   <= 1'b1;
        @(posedge sys_clk);
        send   <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : sample

    task automatic outs(input logic [3:0] st, input logic [3:0] tr);
        compare({28'h0, stage_start}, {28'h0, st});
        compare({28'h0, stage_trip}, {28'h0, tr});
    endtask : outs

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rd_chk(8'h00, 32'h0);
        rd_chk(grp(0, 0, 0), 32'(PICKUP_RESET));
        rd_chk(grp(0, 0, 1), 32'(HALFW_RESET));
        rd_chk(grp(0, 0, 2), 32'(CENTER_RESET));
        rd_chk(grp(0, 0, 3), 32'h0);
        rd_chk(8'h18, 32'h0);
    endtask : t_defaults

    task automatic t_memory();
        u_ang <= 16'h0064;
        repeat (25) @(posedge sys_clk);
        u_ang <= 16'h0000;
        u_mv  <= 16'h03e7;
        rd_chk(8'h14, 32'h0064ff9c);
        repeat (50) @(posedge sys_clk);
        rd_chk(8'h14, 32'h0);
        u_mv  <= 16'h1388;
    endtask : t_memory

    task automatic t_pickup();
        logic [15:0] one [6] = '{16'h0078, 16'h0079, 16'h0075, 16'h0074,
                                 16'h0000, 16'h0000};
        logic [15:0] rest [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0079,
                                  16'h0};
        logic [3:0]  hit [6] = '{4'h0, 4'hf, 4'hf, 4'h0, 4'hf, 4'h0};
        for (int k = 0; k < 6; k++) begin
            sample(one[k], rest[k], 16'h0);
            outs(hit[k], hit[k]);
        end
    endtask : t_pickup

    task automatic t_reference();
        u_ang <= 16'h0708;
        for (int k = 0; k < 3; k++) begin
            sc      <= (k == 0);
            ll_only <= (k == 1);
            sample(16'h0096, 16'h0, 16'h0);
            outs(4'hf, (k < 2) ? 4'hf : 4'h0);
        end
        u_ang <= 16'h0000;
    endtask : t_reference

    task automatic t_direction();
        logic [15:0] ang [4] = '{16'h037a, 16'h0366, 16'h037a, 16'h038e};
        logic [3:0]  hit [4] = '{4'h0, 4'hf, 4'hf, 4'h0};
        for (int k = 0; k < 4; k++) begin
            i_ang <= ang[k];
            sample(16'h0096, 16'h0, 16'h0);
            outs(4'hf, hit[k]);
        end
        apb(1'b1, grp(0, 0, 2), 32'h03b6);
        i_ang <= 16'h03b6;
        sample(16'h0096, 16'h0, 16'h0);
        outs(4'hf, 4'h1);
    endtask : t_direction

    task automatic t_groups();
        apb(1'b1, grp(0, 0, 3), 32'h1);
        i_ang <= 16'hfc7c;
        sample(16'h0096, 16'h0, 16'h0);
        outs(4'hf, 4'h1);
        apb(1'b1, grp(1, 0, 0), 32'h00c8);
        apb(1'b1, 8'h1c, 32'h1);
        sample(16'h0096, 16'h0, 16'h0);
        outs(4'he, 4'h0);
        rd_chk(8'h00, 32'h0);
        apb(1'b1, 8'h1c, 32'h0);
    endtask : t_groups

    task automatic t_modes();
        apb(1'b1, 8'h04, 32'h0200);
        apb(1'b1, 8'h08, 32'h1004);
        apb(1'b1, 8'h0c, 32'h2020);
        sample(16'h0096, 16'h0096, 16'h0);
        compare({28'h0, stage_start & 4'h7}, 32'h1);
        compare({31'h0, stage_trip[3]}, 32'h1);
        sample(16'h0, 16'h0, 16'h0096);
        compare({28'h0, stage_start & 4'h7}, 32'h2);
        apb(1'b1, 8'h08, 32'h0100);
        sample(16'h0, 16'h0096, 16'h0096);
        compare({28'h0, stage_start & 4'h7}, 32'h3);
    endtask : t_modes

    task automatic t_block();
        @(posedge sys_clk);
        rstn     <= 1'b0;
        i_ang    <= 16'h0000;
        repeat (2) @(posedge sys_clk);
        rstn     <= 1'b1;
        block_in <= 4'h2;
        sample(16'h0096, 16'h0, 16'h0);
        outs(4'hd, 4'hd);
        compare({28'h0, stage_blocked}, 32'h2);
        block_in <= 4'h0;
        sample(16'h0096, 16'h0, 16'h0);
        compare({28'h0, stage_blocked}, 32'h0);
    endtask : t_block

    // Cut a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    // Main sequence after two reset cycles.
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_defaults();
        t_memory();
        t_pickup();
        t_reference();
        t_direction();
        t_groups();
        t_modes();
        t_block();
        complete_run();
    end
endmodule : dir_overcurrent_block_tb
